// ==== hw/voice_consts.svh ====
// register map, field positions, reset values and timing of the voice/dac block
// assumes an 8-bit data-memory bus and a 100 MHz core clock
`ifndef VOICE_CONSTS_SVH
`define VOICE_CONSTS_SVH

// data-memory offsets
`define OFS_ADDR0_HIGH   8'h18
`define OFS_ADDR0_MID    8'h19
`define OFS_ADDR0_LOW    8'h1a
`define OFS_ADDR1_HIGH   8'h1b
`define OFS_ADDR1_MID    8'h1c
`define OFS_ADDR1_LOW    8'h1d
`define OFS_VOICE_CTRL   8'h26
`define OFS_DAC_LOW      8'h27
`define OFS_DAC_HIGH     8'h28
`define OFS_OUTPUT_GAIN  8'h29
`define OFS_ROM_BYTE     8'h2a

// voice_ctrl fields
`define CTRL_DAC_EN_BIT  1
`define CTRL_ROM_EN_BIT  2
`define CTRL_SET_SEL_BIT 4
`define CTRL_NORMAL_BIT  7
`define CTRL_RESET       8'h00

// field layouts
`define HIGH_ADDR_W      5
`define GAIN_MSB         7
`define GAIN_LSB         5
`define SAMPLE_LOW_MSB   7
`define SAMPLE_LOW_LSB   4
`define DATA_RESET       8'h00

// latching time of a voice rom byte
`define LATCH_TIME_NS    4000
`define CLK_PERIOD_NS    10
`define LATCH_CYCLES     ((`LATCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hw/voice_pkg.sv ====
// types shared by the voice rom / dac control block, its checker and its bench
// assumes voice_consts.svh is on the include path
package voice_pkg;

  // one data-memory access from the cpu core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } voice_bus_req_t;

  // what the dac front end sees
  typedef struct packed {
    logic        enable;
    logic [11:0] sample;
    logic [2:0]  gain;
  } dac_out_t;

  // voice rom byte latching sequence
  typedef enum logic [1:0] {
    LATCH_IDLE,
    LATCH_WAIT,
    LATCH_FETCH,
    LATCH_CAPTURE
  } latch_state_t;

endpackage

// ==== hw/voice_rom_and_dac_control.sv ====
// voice rom address latches, voice rom byte latching and dac sample/volume registers
// assumes the cpu core presents one data-memory access per cycle on BUS and that
// read data is taken one cycle after the read strobe; the rom load port only programs
// the array before playback, and a rom address width below 21 bits drops the upper
// latch bits, which suits small test arrays
//
// How it works
// - dac sample is low[7:4] plus high byte
// - low sample register reads zero in bits 3..0
// - eight volume levels from bits 7..5
// - volume register lower nibble reads zero
// - ctrl bit 1 enables dac, else output invalid
// - halt leaves dac enable; only writes change it
// - ctrl bit 2 enables rom; else no access
// - ctrl bit 4 picks address latch set
// - ctrl bit 7 crystal start mode, reset zero
// - ctrl bits 0,3,5,6 read as zero
// - each set forms 21-bit byte address
// - software waits 4 us before reading byte
// - byte register returns rom byte at address
`include "voice_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module voice_rom_and_dac_control #(
  parameter int ROM_AW       = 21,
  parameter int LATCH_CYCLES = `LATCH_CYCLES
) (
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST,
  input  wire voice_pkg::voice_bus_req_t BUS,
  output logic      [7:0]               RD_DATA,
  input  wire logic                     ROM_LOAD_EN,
  input  wire logic [ROM_AW-1:0]        ROM_LOAD_ADDR,
  input  wire logic [7:0]               ROM_LOAD_DATA,
  output voice_pkg::dac_out_t           DAC,
  output logic                          XTAL_NORMAL_MODE,
  output logic                          LATCH_BUSY
);
  import voice_pkg::*;

  // counter width, and the wait that leaves two cycles for fetch and capture
  localparam int CNT_W = $clog2(LATCH_CYCLES + 1);
  localparam int WAIT_CYCLES = (LATCH_CYCLES > 2) ? LATCH_CYCLES - 2 : 1;

  // reset images; single bits are picked from these, as bit selects need a named constant
  localparam logic [7:0] CTRL_RST = `CTRL_RESET;
  localparam logic [7:0] DATA_RST = `DATA_RESET;

  // control register fields
  logic dac_en_reg;
  logic rom_en_reg;
  logic set_sel_reg;
  logic normal_mode_reg;

  // data registers
  logic [3:0] dac_low_reg;
  logic [7:0] dac_high_reg;
  logic [2:0] gain_reg;
  logic [7:0] rom_byte_reg;

  // two address latch sets, index 0 and 1
  logic [`HIGH_ADDR_W-1:0] addr_high_reg [0:1];
  logic [7:0]              addr_mid_reg  [0:1];
  logic [7:0]              addr_low_reg  [0:1];
  logic [20:0]             set_addr      [0:1];

  // latching sequence
  latch_state_t      state_reg;
  latch_state_t      state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic              restart;
  logic              rom_rd_en;
  logic [ROM_AW-1:0] rom_rd_addr;
  logic [7:0]        rom_rd_data;

  // bus and output registers
  logic [7:0] rd_data_reg;
  dac_out_t   dac_reg;

  // write decode and the rom enable as it stands after this edge
  logic wr_ctrl;
  logic wr_dac_low;
  logic wr_dac_high;
  logic wr_gain;
  logic wr_set_any;
  logic rom_en_next;
  logic latch_done;

  // joins the three latch registers into one rom byte address
  function automatic logic [20:0] join_addr(input logic [`HIGH_ADDR_W-1:0] hi,
                                            input logic [7:0] mid,
                                            input logic [7:0] lo);
    join_addr = {hi, mid, lo};
  endfunction

  // true when a write strobe hits the given offset;
  // a read in the same cycle still sees the old value
  function automatic logic wr_hit(input voice_bus_req_t req, input logic [7:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  // true when the access touches any address latch register of a set;
  // the six offsets are contiguous, so one range compare covers both sets
  function automatic logic is_set_reg(input logic [7:0] a);
    is_set_reg = (a >= `OFS_ADDR0_HIGH) && (a <= `OFS_ADDR1_LOW);
  endfunction

  // voice control register: written only by software, so halt cannot touch it;
  // writes to the unused bits are dropped and those bits read back as zero
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dac_en_reg      <= CTRL_RST[`CTRL_DAC_EN_BIT];
      rom_en_reg      <= CTRL_RST[`CTRL_ROM_EN_BIT];
      set_sel_reg     <= CTRL_RST[`CTRL_SET_SEL_BIT];
      normal_mode_reg <= CTRL_RST[`CTRL_NORMAL_BIT];
    end else if (wr_ctrl) begin
      dac_en_reg      <= BUS.wdata[`CTRL_DAC_EN_BIT];
      rom_en_reg      <= BUS.wdata[`CTRL_ROM_EN_BIT];
      set_sel_reg     <= BUS.wdata[`CTRL_SET_SEL_BIT];
      normal_mode_reg <= BUS.wdata[`CTRL_NORMAL_BIT];
    end
  end

  // dac sample and volume registers; the unused low nibbles are simply not stored
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dac_low_reg  <= DATA_RST[3:0];
      dac_high_reg <= DATA_RST;
      gain_reg     <= DATA_RST[2:0];
    end else begin
      if (wr_dac_low) begin
        dac_low_reg <= BUS.wdata[`SAMPLE_LOW_MSB:`SAMPLE_LOW_LSB];
      end
      if (wr_dac_high) begin
        dac_high_reg <= BUS.wdata;
      end
      if (wr_gain) begin
        gain_reg <= BUS.wdata[`GAIN_MSB:`GAIN_LSB];
      end
    end
  end

  // address latch sets; high registers keep only the five address bits
  // both sets are written and read alike; only the fetch looks at the set select
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_set
      localparam logic [7:0] OFS_HI = (s == 0) ? `OFS_ADDR0_HIGH : `OFS_ADDR1_HIGH;
      localparam logic [7:0] OFS_MD = (s == 0) ? `OFS_ADDR0_MID  : `OFS_ADDR1_MID;
      localparam logic [7:0] OFS_LO = (s == 0) ? `OFS_ADDR0_LOW  : `OFS_ADDR1_LOW;

      always_ff @(posedge CORE_CLK) begin
        if (RST) begin
          addr_high_reg[s] <= DATA_RST[`HIGH_ADDR_W-1:0];
          addr_mid_reg[s]  <= `DATA_RESET;
          addr_low_reg[s]  <= `DATA_RESET;
        end else begin
          if (wr_hit(BUS, OFS_HI)) begin
            addr_high_reg[s] <= BUS.wdata[`HIGH_ADDR_W-1:0];
          end
          if (wr_hit(BUS, OFS_MD)) begin
            addr_mid_reg[s] <= BUS.wdata;
          end
          if (wr_hit(BUS, OFS_LO)) begin
            addr_low_reg[s] <= BUS.wdata;
          end
        end
      end

      // this set's 21-bit byte address, ready for the fetch
      assign set_addr[s] = join_addr(addr_high_reg[s], addr_mid_reg[s], addr_low_reg[s]);
    end
  endgenerate

  // any change of an address or of the set choice, or turning the rom enable on, restarts latching,
  // so a half-written address is never taken for the final one
  assign restart = wr_set_any || wr_ctrl;

  // write decode, shared by the register processes and the latching restart
  assign wr_ctrl     = wr_hit(BUS, `OFS_VOICE_CTRL);
  assign wr_dac_low  = wr_hit(BUS, `OFS_DAC_LOW);
  assign wr_dac_high = wr_hit(BUS, `OFS_DAC_HIGH);
  assign wr_gain     = wr_hit(BUS, `OFS_OUTPUT_GAIN);
  assign wr_set_any  = BUS.wr && is_set_reg(BUS.addr);

  // the rom enable as it will stand after this edge: a control write that turns the
  // rom circuit on starts a latch at once, and one that turns it off ends a running
  // latch at once, so busy never lingers on a disabled rom
  assign rom_en_next = wr_ctrl ? BUS.wdata[`CTRL_ROM_EN_BIT] : rom_en_reg;

  // latching sequence: wait out the latch time, read the array, then capture.
  // the write edge loads the counter, the wait state runs LATCH_CYCLES-2 cycles,
  // fetch reads the array and capture moves the byte over LATCH_CYCLES edges after
  // the write; with the default count at 10 ns that meets the 4 us software wait
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LATCH_IDLE: begin
        state_next = LATCH_IDLE;
      end
      LATCH_WAIT: begin
        if (cnt_reg == CNT_W'(1)) begin
          state_next = LATCH_FETCH;
        end
      end
      LATCH_FETCH: begin
        state_next = LATCH_CAPTURE;
      end
      LATCH_CAPTURE: begin
        state_next = LATCH_IDLE;
      end
      default: begin
        state_next = LATCH_IDLE;
      end
    endcase
    if (!rom_en_next) begin
      state_next = LATCH_IDLE;
    end else if (restart) begin
      state_next = LATCH_WAIT;
    end
  end

  // state register
  // reset parks the sequence in idle, so a reset in mid-latch drops the byte
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_reg <= LATCH_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // latch-time counter; fetch plus capture take the last two cycles
  // it reloads on every restart, so only the last address write counts
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cnt_reg <= '0;
    end else if (restart) begin
      cnt_reg <= CNT_W'(WAIT_CYCLES);
    end else if (state_reg == LATCH_WAIT && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // rom read only while the rom circuit is on
  assign rom_rd_en = (state_reg == LATCH_FETCH) && rom_en_reg;
  assign rom_rd_addr = ROM_AW'(set_addr[set_sel_reg]);

  // the array; its registered read port is the only way a byte leaves it
  voice_rom_mem #(
    .AW (ROM_AW)
  ) u_rom (
    .clk     (CORE_CLK),
    .rst     (RST),
    .wr_en   (ROM_LOAD_EN),
    .wr_addr (ROM_LOAD_ADDR),
    .wr_data (ROM_LOAD_DATA),
    .rd_en   (rom_rd_en),
    .rd_addr (rom_rd_addr),
    .rd_data (rom_rd_data)
  );

  // a latch completes only with the rom on and no restart on the capture edge
  assign latch_done = (state_reg == LATCH_CAPTURE) && rom_en_reg && !restart;

  // voice rom byte register holds the last byte latched
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rom_byte_reg <= `DATA_RESET;
    end else if (latch_done) begin
      rom_byte_reg <= rom_rd_data;
    end
  end

  // register read mux; unmapped offsets read zero
  // reads have no side effects, so polling any register is safe while latching runs
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    if (a == `OFS_ADDR0_HIGH) begin
      read_mux = {3'h0, addr_high_reg[0]};
    end else if (a == `OFS_ADDR0_MID) begin
      read_mux = addr_mid_reg[0];
    end else if (a == `OFS_ADDR0_LOW) begin
      read_mux = addr_low_reg[0];
    end else if (a == `OFS_ADDR1_HIGH) begin
      read_mux = {3'h0, addr_high_reg[1]};
    end else if (a == `OFS_ADDR1_MID) begin
      read_mux = addr_mid_reg[1];
    end else if (a == `OFS_ADDR1_LOW) begin
      read_mux = addr_low_reg[1];
    end else if (a == `OFS_VOICE_CTRL) begin
      read_mux = 8'h00;
      read_mux[`CTRL_DAC_EN_BIT]  = dac_en_reg;
      read_mux[`CTRL_ROM_EN_BIT]  = rom_en_reg;
      read_mux[`CTRL_SET_SEL_BIT] = set_sel_reg;
      read_mux[`CTRL_NORMAL_BIT]  = normal_mode_reg;
    end else if (a == `OFS_DAC_LOW) begin
      read_mux = {dac_low_reg, 4'h0};
    end else if (a == `OFS_DAC_HIGH) begin
      read_mux = dac_high_reg;
    end else if (a == `OFS_OUTPUT_GAIN) begin
      read_mux = {gain_reg, 5'h00};
    end else if (a == `OFS_ROM_BYTE) begin
      read_mux = rom_byte_reg;
    end else begin
      read_mux = 8'h00;
    end
  endfunction

  // read data is held until the next read strobe;
  // a read of the byte register during a latch returns the previous byte
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rd_data_reg <= 8'h00;
    end else if (BUS.rd) begin
      rd_data_reg <= read_mux(BUS.addr);
    end
  end

  // dac front end: a disabled converter shows zero and a low enable,
  // so stale samples never reach the speaker;
  // the enable follows only the control bit, as no halt input reaches this block
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dac_reg <= '0;
    end else begin
      dac_reg.enable <= dac_en_reg;
      dac_reg.sample <= dac_en_reg ? {dac_high_reg, dac_low_reg} : 12'h000;
      dac_reg.gain   <= gain_reg;
    end
  end

  // outputs come straight from registers, except busy, which is decoded from the state register
  assign RD_DATA          = rd_data_reg;
  assign DAC              = dac_reg;
  assign XTAL_NORMAL_MODE = normal_mode_reg;
  assign LATCH_BUSY       = (state_reg != LATCH_IDLE);

endmodule // voice_rom_and_dac_control

`default_nettype wire

// ==== hw/voice_rom_mem.sv ====
// voice rom array: one write port for programming, one registered read port
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module voice_rom_mem #(
  parameter int AW = 21
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);

  logic [7:0] mem [0:(1<<AW)-1];

  // array itself has no reset; contents come from programming
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data leaves through a register
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // voice_rom_mem

`default_nettype wire

// ==== verif/voice_ctl_properties.sv ====
// checker for the voice rom / dac control block, bound to its top module
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module voice_ctl_checker #(
  parameter int LATCH_CYCLES = 4
) (
  input wire logic                      CORE_CLK,
  input wire logic                      RST,
  input wire voice_pkg::voice_bus_req_t BUS,
  input wire logic [7:0]                RD_DATA,
  input wire voice_pkg::dac_out_t       DAC,
  input wire logic                      XTAL_NORMAL_MODE,
  input wire logic                      LATCH_BUSY
);
  import voice_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  int busy_run;
  logic restart;
  logic rom_off_wr;
  // run length of busy since the last address or control write, so a restart
  // cannot hide a short final wait; an abort by clearing the rom enable is exempt
  assign restart = BUS.wr && ((BUS.addr >= 8'h18 && BUS.addr <= 8'h1d) || BUS.addr == 8'h26);
  assign rom_off_wr = BUS.wr && BUS.addr == 8'h26 && !BUS.wdata[2];
  always_ff @(posedge CORE_CLK) busy_run <= (RST || !LATCH_BUSY || restart) ? 0 : busy_run + 1;
  busy_span_a:
    assert property ($fell(LATCH_BUSY) && !$past(rom_off_wr) |-> busy_run >= LATCH_CYCLES)
      else $error("latch short");
  dac_off_a:
    assert property (!DAC.enable |-> DAC.sample == 12'h000) else $error("dac off output");
  gain_track_a:
    assert property (BUS.wr && BUS.addr == 8'h29 |=> ##1 DAC.gain == ($past(BUS.wdata, 2) >> 5))
      else $error("gain wrong");
  enable_track_a:
    assert property (BUS.wr && BUS.addr == 8'h26 |=> ##1 DAC.enable == $past(BUS.wdata[1], 2))
      else $error("enable wrong");
  xtal_mode_a:
    assert property (BUS.wr && BUS.addr == 8'h26 |=> XTAL_NORMAL_MODE == $past(BUS.wdata[7]))
      else $error("xtal mode wrong");
  ctrl_zero_a:
    assert property (BUS.rd && BUS.addr == 8'h26 |=> (RD_DATA & 8'h69) == 8'h00)
      else $error("ctrl unused set");
  sample_low_a:
    assert property (BUS.rd && BUS.addr == 8'h27 |=> RD_DATA[3:0] == 4'h0) else $error("low bits");
  gain_low_a:
    assert property (BUS.rd && BUS.addr == 8'h29 |=> RD_DATA[3:0] == 4'h0) else $error("gain bits");
  rom_off_a:
    assert property (BUS.wr && BUS.addr == 8'h26 && !BUS.wdata[2] |=> !LATCH_BUSY [*2])
      else $error("latch while off");
endmodule // voice_ctl_checker
bind voice_rom_and_dac_control voice_ctl_checker #(.LATCH_CYCLES(LATCH_CYCLES)) i_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .BUS(BUS), .RD_DATA(RD_DATA), .DAC(DAC),
  .XTAL_NORMAL_MODE(XTAL_NORMAL_MODE), .LATCH_BUSY(LATCH_BUSY));
`default_nettype wire

// ==== verif/voice_rom_and_dac_control_tb_top.sv ====
// self-checking bench of the voice rom / dac control block
// assumes the block with an 8-bit rom address and a 4-cycle latch wait
`timescale 1ns/10ps
`default_nettype none
`define CHECK(n, e, s) begin checks_done++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module voice_rom_and_dac_control_tb_top;
  import voice_pkg::*;
  typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } row_t;
  logic           core_clk = 0;
  logic           rst = 1;
  voice_bus_req_t bus = '0;
  logic [7:0]     rd_data;
  dac_out_t       dac;
  logic           xtal, busy, ld_en, ld_done;
  logic [7:0]     ld_addr, ld_data, v;
  int             errors = 0;
  int             checks_done = 0;
  row_t rows[11] = '{'{8'h2a, 8'hff, 8'h00}, '{8'h26, 8'hff, 8'h96}, '{8'h27, 8'hff, 8'hf0},
    '{8'h28, 8'ha5, 8'ha5}, '{8'h29, 8'hff, 8'he0}, '{8'h18, 8'hff, 8'h1f},
    '{8'h19, 8'h3c, 8'h3c}, '{8'h1a, 8'hc3, 8'hc3}, '{8'h1b, 8'h0a, 8'h0a},
    '{8'h1d, 8'h21, 8'h21}, '{8'h2b, 8'hff, 8'h00}};
  always #5 core_clk = ~core_clk;
  voice_rom_and_dac_control #(.ROM_AW(8), .LATCH_CYCLES(4)) i_dut (.CORE_CLK(core_clk),
    .RST(rst), .BUS(bus), .RD_DATA(rd_data), .ROM_LOAD_EN(ld_en), .ROM_LOAD_ADDR(ld_addr),
    .ROM_LOAD_DATA(ld_data), .DAC(dac), .XTAL_NORMAL_MODE(xtal), .LATCH_BUSY(busy));
  voice_rom_loader #(.AW(8)) i_rom (.clk(core_clk), .rst(rst), .load_en(ld_en),
    .load_addr(ld_addr), .load_data(ld_data), .done(ld_done));
  task final_report;
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one-cycle strobes, dropped at the next falling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) bus = '{1'b1, 1'b0, a, d};
    @(negedge core_clk) bus = '0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge core_clk) bus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk) bus = '0;
    v = rd_data;
  endtask
  task idle;
    int n;
    n = 0;
    @(negedge core_clk);
    while (busy && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    `CHECK("idle", 1'b0, busy)
  endtask
  // a hang counts as a failure
  initial begin
    #100us;
    errors++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 0;
    wait (ld_done);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHECK("reg", rows[i].e, v)
    end
    `CHECK("dac", {1'b1, 12'ha5f, 3'h7}, dac)
    `CHECK("xtal", 1'b1, xtal)
    idle();
    rd(8'h2a);
    `CHECK("set1", 8'h21 ^ 8'h5a, v)
    wr(8'h26, 8'h04);
    idle();
    rd(8'h2a);
    `CHECK("set0", 8'hc3 ^ 8'h5a, v)
    wr(8'h1a, 8'h07);
    rd(8'h2a);
    `CHECK("early", 8'hc3 ^ 8'h5a, v)
    idle();
    rd(8'h2a);
    `CHECK("late", 8'h07 ^ 8'h5a, v)
    wr(8'h1a, 8'h09);
    wr(8'h26, 8'h00);
    repeat (10) @(negedge core_clk);
    rd(8'h2a);
    `CHECK("off", 8'h07 ^ 8'h5a, v)
    wr(8'h26, 8'h04);
    idle();
    rd(8'h2a);
    `CHECK("rom on", 8'h09 ^ 8'h5a, v)
    for (int g = 0; g < 8; g++) begin
      wr(8'h29, {3'(g), 5'h1f});
      @(negedge core_clk);
      `CHECK("gain", 3'(g), dac.gain)
    end
    `CHECK("dacoff", {1'b0, 12'h000}, {dac.enable, dac.sample})
    wr(8'h26, 8'h82);
    @(negedge core_clk) rst = 1;
    @(negedge core_clk);
    `CHECK("rst", 3'b000, {dac.enable, xtal, busy})
    rst = 0;
    rd(8'h26);
    `CHECK("ctrl", 8'h00, v)
    final_report();
  end
endmodule // voice_rom_and_dac_control_tb_top
`default_nettype wire

// ==== verif/voice_rom_loader.sv ====
// voice rom array contents: programs byte a ^ 5a at every address a
// assumes the block's load port and a clock driven at falling edges
`timescale 1ns/10ps
`default_nettype none
module voice_rom_loader #(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  output logic               load_en,
  output logic      [AW-1:0] load_addr,
  output logic      [7:0]    load_data,
  output logic               done
);
  // one byte per cycle, then the data lines wander so stale data is never trusted
  initial begin
    {load_en, load_addr, load_data, done} = '0;
    @(negedge clk iff !rst);
    for (int i = 0; i < 2**AW; i++) begin
      @(negedge clk);
      load_en = 1'b1;
      load_addr = AW'(i);
      load_data = 8'(i) ^ 8'h5a;
    end
    @(negedge clk);
    load_en = 1'b0;
    done = 1'b1;
    forever @(negedge clk) load_data = ~load_data;
  end
endmodule // voice_rom_loader
`default_nettype wire
